/* rtl/uicr_pkg.sv */
// Behaviour
// - Reads 07h-09h return contents; write/set/clear
// - Protect on: STP pull-up, high STP pulls data outside serial mode
// - Protect on: detect floating stop line outside serial mode
// - Protect off: drop all protect pulls
// - Fault output never qualified by VBUS comparator
// - Invert bit selects fault inversion
// - Clock sleep bit gates clock power only
// - Clock sleep bit one keeps serial clock
// - Clock bit honoured only serial and awake
// - Three-wire bit selects 3-pin serial interface
// - Device clears three-wire bit on exit
// - Six-wire bit selects 6-pin serial interface
// - Device clears six-wire bit on exit
// - Sleep bit in function control, stop wakes
package uicr_pkg;

  // ==========================================================
  // Register map
  localparam logic [5:0] UICR_ADDR_WRITE = 6'h07;
  localparam logic [5:0] UICR_ADDR_SET   = 6'h08;
  localparam logic [5:0] UICR_ADDR_CLEAR = 6'h09;
  localparam int         UICR_ADDR_W     = 6;
  localparam int         UICR_DATA_W     = 8;

  // ==========================================================
  // Field positions
  localparam int UICR_BIT_PROTECT_OFF = 7;
  localparam int UICR_BIT_NO_QUALIFY  = 6;
  localparam int UICR_BIT_INVERT      = 5;
  localparam int UICR_BIT_CLOCK_SLEEP = 3;
  localparam int UICR_BIT_THREE_WIRE  = 1;
  localparam int UICR_BIT_SIX_WIRE    = 0;

  // ==========================================================
  // Reset value and implemented bits
  localparam logic [7:0] UICR_RESET_VALUE = 8'h00;
  localparam logic [7:0] UICR_WRITE_MASK  = 8'hEB;

endpackage

/* rtl/uicr_top.sv */
`timescale 1ns/1ns
module uicr_top
  #(parameter int DATA_LINES = 8)
  (
  input  wire logic                             core_clk,
  input  wire logic                             reset,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  input  wire logic [uicr_pkg::UICR_ADDR_W-1:0] reg_addr,
  input  wire logic [uicr_pkg::UICR_DATA_W-1:0] reg_wdata,
  output logic      [uicr_pkg::UICR_DATA_W-1:0] reg_rdata,
  output logic                                  reg_rd_valid,
  input  wire logic                             phy_sleep_n,
  input  wire logic                             link_clk,
  input  wire logic                             stp_in,
  input  wire logic                             vbus_fault_in,
  output logic                                  stp_pullup_en,
  output logic      [DATA_LINES-1:0]            data_pulldown_en,
  output logic                                  fault_compl_out,
  output logic                                  clock_power_en,
  output logic                                  three_wire_active,
  output logic                                  six_wire_active,
  output logic      [uicr_pkg::UICR_DATA_W-1:0] ctrl_value
  );
  import uicr_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0]            ctrl;
    logic [7:0]            rdata;
    logic                  rd_valid;
    logic                  stp_s1;
    logic                  stp_s2;
    logic                  lclk_s1;
    logic                  lclk_s2;
    logic                  lclk_d;
    logic                  flt_s1;
    logic                  flt_s2;
    logic                  stp_float;
    logic                  stp_pullup;
    logic [DATA_LINES-1:0] data_pd;
    logic                  fault_compl;
    logic                  clk_pwr;
    logic                  ser3;
    logic                  ser6;
  } uicr_state_t;

  uicr_state_t st;
  uicr_state_t next_st;

  function automatic logic in_window(input logic [5:0] a);
    in_window = (a == UICR_ADDR_WRITE) || (a == UICR_ADDR_SET) ||
                (a == UICR_ADDR_CLEAR);
  endfunction

  logic link_edge;
  logic serial_on;
  logic prot_off;
  assign link_edge = st.lclk_s2 & ~st.lclk_d;
  assign serial_on = st.ctrl[UICR_BIT_THREE_WIRE] |
                     st.ctrl[UICR_BIT_SIX_WIRE];
  assign prot_off  = st.ctrl[UICR_BIT_PROTECT_OFF];

  // ==========================================================
  // Next state
  always_comb
  begin
    next_st = st;
    next_st.stp_s1  = stp_in;
    next_st.stp_s2  = st.stp_s1;
    next_st.lclk_s1 = link_clk;
    next_st.lclk_s2 = st.lclk_s1;
    next_st.lclk_d  = st.lclk_s2;
    next_st.flt_s1  = vbus_fault_in;
    next_st.flt_s2  = st.flt_s1;

    // Stop high at a link edge ends serial mode
    if (serial_on && link_edge && st.stp_s2)
    begin
      next_st.ctrl[UICR_BIT_THREE_WIRE] = 1'b0;
      next_st.ctrl[UICR_BIT_SIX_WIRE]   = 1'b0;
    end

    // Register writes win over the self-clear
    if (reg_wr)
    begin
      unique case (reg_addr)
        UICR_ADDR_WRITE:
          next_st.ctrl = reg_wdata & UICR_WRITE_MASK;
        UICR_ADDR_SET:
          next_st.ctrl = st.ctrl | (reg_wdata & UICR_WRITE_MASK);
        UICR_ADDR_CLEAR:
          next_st.ctrl = st.ctrl & ~reg_wdata;
        default:
          next_st.ctrl = next_st.ctrl;
      endcase
    end

    next_st.rd_valid = reg_rd;
    next_st.rdata    = (reg_rd && in_window(reg_addr)) ? st.ctrl
                                                      : 8'h00;

    // Floating stop line caught by the weak pull-up
    if (prot_off || serial_on)
      next_st.stp_float = 1'b0;
    else if (link_edge)
      next_st.stp_float = st.stp_s2;

    next_st.stp_pullup = ~prot_off;
    next_st.data_pd = {DATA_LINES{next_st.stp_float & ~prot_off}};

    // No comparator term: fault pin only
    next_st.fault_compl = st.flt_s2 ^
                          st.ctrl[UICR_BIT_INVERT];

    if (serial_on && phy_sleep_n)
      next_st.clk_pwr = st.ctrl[UICR_BIT_CLOCK_SLEEP];
    else if (serial_on)
      next_st.clk_pwr = 1'b0;
    else
      next_st.clk_pwr = 1'b1;

    next_st.ser3 = st.ctrl[UICR_BIT_THREE_WIRE];
    next_st.ser6 = st.ctrl[UICR_BIT_SIX_WIRE];
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st            <= '0;
      st.ctrl       <= UICR_RESET_VALUE;
      st.stp_pullup <= 1'b1;
      st.clk_pwr    <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // Outputs
  assign reg_rdata         = st.rdata;
  assign reg_rd_valid      = st.rd_valid;
  assign stp_pullup_en     = st.stp_pullup;
  assign data_pulldown_en  = st.data_pd;
  assign fault_compl_out   = st.fault_compl;
  assign clock_power_en    = st.clk_pwr;
  assign three_wire_active = st.ser3;
  assign six_wire_active   = st.ser6;
  assign ctrl_value        = st.ctrl;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_exit_cond;
    serial_on && link_edge && st.stp_s2 && !reg_wr;
  endsequence

  sequence s_mode_bits_clear;
    !ctrl_value[UICR_BIT_THREE_WIRE] && !ctrl_value[UICR_BIT_SIX_WIRE];
  endsequence

  sequence s_mode_outputs_off;
    !three_wire_active && !six_wire_active;
  endsequence

  sequence s_float_seen;
    !prot_off && !serial_on && link_edge && st.stp_s2;
  endsequence

  sequence s_drive_seen;
    !prot_off && !serial_on && link_edge && !st.stp_s2;
  endsequence

  property p_read;
    reg_rd && in_window(reg_addr)
      |=> reg_rd_valid && reg_rdata == $past(st.ctrl);
  endproperty
  a_read: assert property (p_read)
    else $error("read data does not match control register");

  property p_read_outside;
    reg_rd && !in_window(reg_addr)
      |=> reg_rd_valid && reg_rdata == 8'h00;
  endproperty
  a_read_outside: assert property (p_read_outside)
    else $error("read outside the register returned data");

  property p_read_idle;
    !reg_rd |=> !reg_rd_valid && reg_rdata == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data or valid present without a read");

  property p_write;
    reg_wr && reg_addr == UICR_ADDR_WRITE
      |=> ctrl_value == ($past(reg_wdata) & UICR_WRITE_MASK);
  endproperty
  a_write: assert property (p_write)
    else $error("write did not replace contents");

  property p_set;
    reg_wr && reg_addr == UICR_ADDR_SET
      |=> ctrl_value ==
          ($past(ctrl_value) | ($past(reg_wdata) & UICR_WRITE_MASK));
  endproperty
  a_set: assert property (p_set)
    else $error("set write did not set the written bits");

  property p_clear;
    reg_wr && reg_addr == UICR_ADDR_CLEAR
      |=> ctrl_value == ($past(ctrl_value) & ~$past(reg_wdata));
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear write did not clear the written bits");

  property p_write_other;
    reg_wr && !in_window(reg_addr) && !serial_on
      |=> $stable(ctrl_value);
  endproperty
  a_write_other: assert property (p_write_other)
    else $error("write elsewhere changed the register");

  property p_hold;
    !reg_wr && !(serial_on && link_edge && st.stp_s2)
      |=> $stable(ctrl_value);
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed without a write or an exit");

  property p_reserved;
    (ctrl_value & ~UICR_WRITE_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit reads as one");

  property p_protect_off;
    prot_off |=> !stp_pullup_en && data_pulldown_en == '0;
  endproperty
  a_protect_off: assert property (p_protect_off)
    else $error("protect pulls present while disabled");

  property p_protect_on;
    !prot_off |=> stp_pullup_en;
  endproperty
  a_protect_on: assert property (p_protect_on)
    else $error("stop line pull-up missing while protect on");

  property p_float;
    s_float_seen |=> data_pulldown_en == {DATA_LINES{1'b1}} && stp_pullup_en;
  endproperty
  a_float: assert property (p_float)
    else $error("floating stop line not protected");

  property p_float_release;
    s_drive_seen |=> data_pulldown_en == '0;
  endproperty
  a_float_release: assert property (p_float_release)
    else $error("pull-downs kept after stop line driven low");

  property p_float_serial;
    serial_on |=> data_pulldown_en == '0;
  endproperty
  a_float_serial: assert property (p_float_serial)
    else $error("float detect active in serial mode");

  property p_fault;
    ##1 fault_compl_out ==
        ($past(st.flt_s2) ^ $past(st.ctrl[UICR_BIT_INVERT]));
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault complement wrong");

  property p_clock;
    serial_on && phy_sleep_n
      |=> clock_power_en == $past(st.ctrl[UICR_BIT_CLOCK_SLEEP]);
  endproperty
  a_clock: assert property (p_clock)
    else $error("serial clock power does not follow bit");

  property p_clock_asleep;
    serial_on && !phy_sleep_n |=> !clock_power_en;
  endproperty
  a_clock_asleep: assert property (p_clock_asleep)
    else $error("serial clock powered while asleep");

  property p_clock_idle;
    !serial_on |=> clock_power_en;
  endproperty
  a_clock_idle: assert property (p_clock_idle)
    else $error("clock unpowered outside serial mode");

  property p_exit;
    s_exit_cond |=> s_mode_bits_clear ##1 s_mode_outputs_off;
  endproperty
  a_exit: assert property (p_exit)
    else $error("serial mode bit not cleared on exit");

  property p_mode;
    ##1 three_wire_active == $past(st.ctrl[UICR_BIT_THREE_WIRE]) &&
        six_wire_active == $past(st.ctrl[UICR_BIT_SIX_WIRE]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("serial mode outputs do not follow bits");

endmodule

/* testbench/uicr_link_model.sv */
`timescale 1ns/1ns
module uicr_link_model (
  output logic link_clk,
  output logic stp_in
  );
  initial
  begin
    link_clk = 1'b0;
    stp_in   = 1'b0;
  end
  // One link clock period; the clock stands low between frames
  task automatic frame(input logic stp);
    stp_in = stp;
    #62 link_clk = 1'b1;
    #63 link_clk = 1'b0;
  endtask
endmodule

/* testbench/ulpi_interface_control_reg_test.sv */
`timescale 1ns/1ns
module ulpi_interface_control_reg_test;
  import uicr_pkg::*;
  logic       core_clk, reset, reg_wr, reg_rd, phy_sleep_n, vbus_fault_in;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ctrl_value, data_pulldown_en;
  logic       reg_rd_valid, link_clk, stp_in, stp_pullup_en, fault_compl_out;
  logic       clock_power_en, three_wire_active, six_wire_active;
  int         failures = 0;
  int         num_checks = 0;
  logic [7:0] mode_bits;
  assign mode_bits = {6'h00, three_wire_active, six_wire_active};
  uicr_top uut (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .phy_sleep_n(phy_sleep_n), .link_clk(link_clk), .stp_in(stp_in),
    .vbus_fault_in(vbus_fault_in), .stp_pullup_en(stp_pullup_en),
    .data_pulldown_en(data_pulldown_en), .fault_compl_out(fault_compl_out),
    .clock_power_en(clock_power_en), .three_wire_active(three_wire_active),
    .six_wire_active(six_wire_active), .ctrl_value(ctrl_value));
  uicr_link_model link (.link_clk(link_clk), .stp_in(stp_in));
  // ==========================================================
  // Helpers
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    settle(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk("rd_valid", 8'h01, {7'h00, reg_rd_valid});
    chk("rdata", e, reg_rdata);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    chk("reset ctrl", 8'h00, ctrl_value);
    chk("reset pullup", 8'h01, {7'h00, stp_pullup_en});
    wr(UICR_ADDR_WRITE, 8'h6C);
    chk("write", 8'h68, ctrl_value);
    wr(UICR_ADDR_SET, 8'h80);
    chk("set", 8'hE8, ctrl_value);
    chk("protect off", 8'h00, {7'h00, stp_pullup_en});
    link.frame(1'b1);
    settle(5);
    chk("no pulldown", 8'h00, data_pulldown_en);
    wr(UICR_ADDR_CLEAR, 8'hA0);
    chk("clear", 8'h48, ctrl_value);
    wr(6'h0A, 8'hFF);
    chk("write elsewhere", 8'h48, ctrl_value);
    rd(UICR_ADDR_WRITE, 8'h48);
    rd(UICR_ADDR_SET, 8'h48);
    rd(UICR_ADDR_CLEAR, 8'h48);
    rd(6'h0A, 8'h00);
  endtask
  task automatic t_fault;
    @(posedge core_clk);
    vbus_fault_in <= 1'b1;
    settle(5);
    chk("fault pass", 8'h01, {7'h00, fault_compl_out});
    wr(UICR_ADDR_SET, 8'h20);
    settle(1);
    chk("fault inv", 8'h00, {7'h00, fault_compl_out});
    @(posedge core_clk);
    vbus_fault_in <= 1'b0;
    settle(5);
    chk("fault inv low", 8'h01, {7'h00, fault_compl_out});
    wr(UICR_ADDR_CLEAR, 8'h20);
    chk("fault pass low", 8'h00, {7'h00, fault_compl_out});
  endtask
  task automatic t_protect;
    link.frame(1'b1);
    settle(5);
    chk("float pd", 8'hFF, data_pulldown_en);
    link.frame(1'b0);
    settle(5);
    chk("driven pd", 8'h00, data_pulldown_en);
  endtask
  task automatic t_serial(input logic [7:0] m);
    wr(UICR_ADDR_WRITE, 8'h40 | m);
    settle(1);
    chk("mode", m, mode_bits);
    chk("clk off", 8'h00, {7'h00, clock_power_en});
    wr(UICR_ADDR_SET, 8'h08);
    settle(1);
    chk("clk on", 8'h01, {7'h00, clock_power_en});
    @(posedge core_clk);
    phy_sleep_n <= 1'b0;
    settle(2);
    chk("clk asleep", 8'h00, {7'h00, clock_power_en});
    @(posedge core_clk);
    phy_sleep_n <= 1'b1;
    settle(1);
    link.frame(1'b1);
    settle(5);
    chk("mode exit", 8'h48, ctrl_value);
    chk("mode off", 8'h00, mode_bits);
    chk("clk idle", 8'h01, {7'h00, clock_power_en});
  endtask
  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    {reset, reg_wr, reg_rd, vbus_fault_in} = 4'h8;
    {reg_addr, reg_wdata, phy_sleep_n} = 15'h0001;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    settle(5);
    t_regs();
    t_fault();
    t_protect();
    t_serial(8'h02);
    t_serial(8'h01);
    wrap_up();
  end
  initial
  begin
    #60000;
    failures++;
    wrap_up();
  end
endmodule
